// ==== verilog/rcp_pin_select.v ====
// Reconfigurable pin selector with its I/O space registers.
// What this block does
// - Up to 29 pins switch between peripheral and general purpose: in groups, or singly for the chip selects.
// - Function select register at EFC0h, direction register at EFC4h to EFC7h.
// - System reset returns every pin to its peripheral function.
// - Bit 7 set turns the card interface pins into general bits 31-24.
// - Bit 6 set turns the display pins into general bits 22-16.
// - Bit 5 set turns the printer data pins into general bits 15-8.
// - Bit 4 set turns serial receive and clock input into general bits 5, 4.
// - Bits 3 to 0 each turn one chip select into general bits 3 to 0.
// - A released pin drives its output latch when its direction bit is one.
// - Direction bits clear to zero on reset, so released pins start as inputs.
// - With the group bit clear, direction bits have no effect on the pins.
// - The input register reads every pin level whatever its function.
`timescale 1ns/1ps
`include "rcp_defs.vh"
module rcp_pin_select (
	// Clock and reset.
	input wire ref_clk,
	input wire reset,
	// I/O space byte access.
	input wire [15:0] io_addr,
	input wire io_wr,
	input wire io_rd,
	input wire [7:0] io_wdata,
	output reg [7:0] io_rdata_r,
	// Peripheral drivers, one bit per general purpose bit position.
	input wire [31:0] per_out,
	input wire [31:0] per_oe,
	// Pins.
	input wire [31:0] pin_level,
	output wire [31:0] pin_data,
	output wire [31:0] pin_oe,
	// Peripheral view of the pin levels.
	output reg [31:0] per_level_r
);

	// ************************************************************
	// Declarations
	// ************************************************************

	reg [7:0] pin_function_select_r;
	reg [31:0] pin_direction_r;
	reg [31:0] out_latch_r;
	reg [7:0] rdata_nxt;
	wire sel_hit;
	wire [3:0] dir_hit;
	wire [3:0] in_hit;
	wire [3:0] out_hit;
	wire [31:0] gp_sel;
	wire [31:0] pin_data_cell;
	wire [31:0] pin_oe_cell;

	// ************************************************************
	// Address match
	// ************************************************************

	assign sel_hit = io_addr == `RCP_PIN_FUNC_SEL_ADDR;
	assign dir_hit[0] = io_addr == `RCP_DIR_ADDR0;
	assign dir_hit[1] = io_addr == `RCP_DIR_ADDR1;
	assign dir_hit[2] = io_addr == `RCP_DIR_ADDR2;
	assign dir_hit[3] = io_addr == `RCP_DIR_ADDR3;
	assign in_hit[0] = io_addr == `RCP_IN_ADDR0;
	assign in_hit[1] = io_addr == `RCP_IN_ADDR1;
	assign in_hit[2] = io_addr == `RCP_IN_ADDR2;
	assign in_hit[3] = io_addr == `RCP_IN_ADDR3;
	assign out_hit[0] = io_addr == `RCP_OUT_ADDR0;
	assign out_hit[1] = io_addr == `RCP_OUT_ADDR1;
	assign out_hit[2] = io_addr == `RCP_OUT_ADDR2;
	assign out_hit[3] = io_addr == `RCP_OUT_ADDR3;

	// ************************************************************
	// Function select register
	// ************************************************************

	always @(posedge ref_clk) begin
		if (reset) begin
			pin_function_select_r <= `RCP_SEL_RESET;
		end else if (io_wr && sel_hit) begin
			pin_function_select_r <= io_wdata;
		end
	end

	// ************************************************************
	// Direction register
	// ************************************************************

	always @(posedge ref_clk) begin
		if (reset) begin
			pin_direction_r <= `RCP_DIR_RESET;
		end else if (io_wr) begin
			if (dir_hit[0]) begin
				pin_direction_r[7:0] <= io_wdata;
			end else if (dir_hit[1]) begin
				pin_direction_r[15:8] <= io_wdata;
			end else if (dir_hit[2]) begin
				pin_direction_r[23:16] <= io_wdata;
			end else if (dir_hit[3]) begin
				pin_direction_r[31:24] <= io_wdata;
			end
		end
	end

	// ************************************************************
	// Output latch
	// ************************************************************

	always @(posedge ref_clk) begin
		if (reset) begin
			out_latch_r <= `RCP_OUT_RESET;
		end else if (io_wr) begin
			if (out_hit[0]) begin
				out_latch_r[7:0] <= io_wdata;
			end else if (out_hit[1]) begin
				out_latch_r[15:8] <= io_wdata;
			end else if (out_hit[2]) begin
				out_latch_r[23:16] <= io_wdata;
			end else if (out_hit[3]) begin
				out_latch_r[31:24] <= io_wdata;
			end
		end
	end

	// ************************************************************
	// Read decode
	// ************************************************************

	always @* begin
		rdata_nxt = 8'h00;
		if (sel_hit) begin
			rdata_nxt = pin_function_select_r;
		end else if (dir_hit[0]) begin
			rdata_nxt = pin_direction_r[7:0];
		end else if (dir_hit[1]) begin
			rdata_nxt = pin_direction_r[15:8];
		end else if (dir_hit[2]) begin
			rdata_nxt = pin_direction_r[23:16];
		end else if (dir_hit[3]) begin
			rdata_nxt = pin_direction_r[31:24];
		end else if (in_hit[0]) begin
			rdata_nxt = pin_level[7:0];
		end else if (in_hit[1]) begin
			rdata_nxt = pin_level[15:8];
		end else if (in_hit[2]) begin
			rdata_nxt = pin_level[23:16];
		end else if (in_hit[3]) begin
			rdata_nxt = pin_level[31:24];
		end else if (out_hit[0]) begin
			rdata_nxt = out_latch_r[7:0];
		end else if (out_hit[1]) begin
			rdata_nxt = out_latch_r[15:8];
		end else if (out_hit[2]) begin
			rdata_nxt = out_latch_r[23:16];
		end else if (out_hit[3]) begin
			rdata_nxt = out_latch_r[31:24];
		end
	end

	// ************************************************************
	// Read data
	// ************************************************************

	always @(posedge ref_clk) begin
		if (reset) begin
			io_rdata_r <= 8'h00;
		end else if (io_rd) begin
			io_rdata_r <= rdata_nxt;
		end
	end

	// ************************************************************
	// Pin levels
	// ************************************************************

	always @(posedge ref_clk) begin
		if (reset) begin
			per_level_r <= 32'h00000000;
		end else begin
			per_level_r <= pin_level;
		end
	end

	// ************************************************************
	// Group selects
	// ************************************************************

	assign gp_sel[31:24] = {8{pin_function_select_r[`RCP_BIT_CARD]}};
	assign gp_sel[23] = 1'b0;
	assign gp_sel[22:16] = {7{pin_function_select_r[`RCP_BIT_DISPLAY]}};
	assign gp_sel[15:8] = {8{pin_function_select_r[`RCP_BIT_PRINTER]}};
	assign gp_sel[7:6] = 2'b00;
	assign gp_sel[5:4] = {2{pin_function_select_r[`RCP_BIT_SERIAL]}};
	assign gp_sel[3:0] = pin_function_select_r[3:0];

	// ************************************************************
	// Pin cells
	// ************************************************************

	genvar i;
	generate
		for (i = 0; i < 32; i = i + 1) begin : g_pin
			rcp_pin_cell u_cell (
				.ref_clk(ref_clk),
				.reset(reset),
				.gp_sel(gp_sel[i]),
				.gp_dir(pin_direction_r[i]),
				.gp_out(out_latch_r[i]),
				.per_oe(per_oe[i]),
				.per_out(per_out[i]),
				.pin_data_r(pin_data_cell[i]),
				.pin_oe_r(pin_oe_cell[i])
			);
		end
	endgenerate

	// ************************************************************
	// Pin outputs
	// ************************************************************

	assign pin_data = pin_data_cell;
	assign pin_oe = pin_oe_cell;

endmodule // rcp_pin_select

// ==== verilog/rcp_defs.vh ====
// Constants for the reconfigurable pin selector.
`ifndef RCP_DEFS_VH
`define RCP_DEFS_VH
`define RCP_ADDR_W 16
`define RCP_PIN_FUNC_SEL_ADDR 16'hefc0
`define RCP_DIR_ADDR0 16'hefc4
`define RCP_DIR_ADDR1 16'hefc5
`define RCP_DIR_ADDR2 16'hefc6
`define RCP_DIR_ADDR3 16'hefc7
`define RCP_IN_ADDR0 16'hefc8
`define RCP_IN_ADDR1 16'hefc9
`define RCP_IN_ADDR2 16'hefca
`define RCP_IN_ADDR3 16'hefcb
`define RCP_OUT_ADDR0 16'hefcc
`define RCP_OUT_ADDR1 16'hefcd
`define RCP_OUT_ADDR2 16'hefce
`define RCP_OUT_ADDR3 16'hefcf
`define RCP_SEL_RESET 8'h00
`define RCP_DIR_RESET 32'h00000000
`define RCP_OUT_RESET 32'h00000000
`define RCP_PIN_MASK 32'hff7fff3f
`define RCP_BIT_CARD 7
`define RCP_BIT_DISPLAY 6
`define RCP_BIT_PRINTER 5
`define RCP_BIT_SERIAL 4
`endif

// ==== verilog/rcp_pin_cell.v ====
// One pin multiplexer cell between peripheral and general purpose control.
`timescale 1ns/1ps
module rcp_pin_cell (
	// Clock and reset.
	input wire ref_clk,
	input wire reset,
	// Selection.
	input wire gp_sel,
	input wire gp_dir,
	input wire gp_out,
	// Peripheral side.
	input wire per_oe,
	input wire per_out,
	// Pin side.
	output reg pin_data_r,
	output reg pin_oe_r
);

	// ************************************************************
	// Pin multiplexer
	// ************************************************************

	always @(posedge ref_clk) begin
		if (reset) begin
			pin_data_r <= 1'b0;
			pin_oe_r <= 1'b0;
		end else if (gp_sel) begin
			pin_data_r <= gp_out;
			pin_oe_r <= gp_dir;
		end else begin
			pin_data_r <= per_out;
			pin_oe_r <= per_oe;
		end
	end

endmodule // rcp_pin_cell

// ==== bench/rcp_checker.sv ====
// Port assertions for the pin selector.
`timescale 1ns/1ps
module rcp_checker (
	// Clock and reset.
	input wire ref_clk,
	input wire reset,
	// I/O access.
	input wire [15:0] io_addr,
	input wire io_wr,
	input wire io_rd,
	input wire [7:0] io_wdata,
	input wire [7:0] io_rdata_r,
	// Peripheral side and pins.
	input wire [31:0] per_out,
	input wire [31:0] per_oe,
	input wire [31:0] pin_level,
	input wire [31:0] pin_data,
	input wire [31:0] pin_oe,
	input wire [31:0] per_level_r
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	reset_clear_a: assert property (disable iff (1'b0) reset
		|=> pin_oe == 32'h00000000 && pin_data == 32'h00000000 && io_rdata_r == 8'h00
		&& per_level_r == 32'h00000000)
		else $error("outputs not cleared");
	spare_bits_a: assert property (!$past(reset)
		|-> pin_oe[23] == $past(per_oe[23]) && pin_oe[7:6] == $past(per_oe[7:6])
		&& pin_data[23] == $past(per_out[23]) && pin_data[7:6] == $past(per_out[7:6]))
		else $error("spare bit left peripheral");
	in_sample_a: assert property (!$past(reset) |-> per_level_r == $past(pin_level))
		else $error("pin levels not sampled");
	in_read_a: assert property (io_rd && io_addr == 16'hefc8
		|=> io_rdata_r == $past(pin_level[7:0]))
		else $error("input read wrong");
	unmapped_a: assert property (io_rd && io_addr[15:4] != 12'hefc
		|=> io_rdata_r == 8'h00)
		else $error("unmapped read not zero");
	sel_back_a: assert property (io_wr && io_addr == 16'hefc0
		##1 io_rd && io_addr == 16'hefc0
		|=> io_rdata_r == $past(io_wdata, 2))
		else $error("select readback wrong");
	dir_back_a: assert property (io_wr && io_addr == 16'hefc4
		##1 io_rd && io_addr == 16'hefc4
		|=> io_rdata_r == $past(io_wdata, 2))
		else $error("direction readback wrong");
	per_mode_a: assert property (io_wr && io_addr == 16'hefc0 && io_wdata == 8'h00
		##1 !io_wr
		|=> pin_oe == $past(per_oe) && pin_data == $past(per_out))
		else $error("pins not under peripheral");
endmodule // rcp_checker
bind rcp_pin_select rcp_checker rcp_checker_inst (.ref_clk, .reset, .io_addr, .io_wr, .io_rd,
	.io_wdata, .io_rdata_r, .per_out, .per_oe, .pin_level, .pin_data, .pin_oe, .per_level_r);

// ==== bench/testbench.sv ====
// Self-checking testbench for the pin selector.
`timescale 1ns/1ps
module testbench;
	reg ref_clk = 0, reset = 1, io_wr = 0, io_rd = 0;
	reg [15:0] io_addr = 0;
	reg [7:0] io_wdata = 0;
	reg [31:0] per_out = 32'h5a5a_a5a5, per_oe = 0, pin_level = 32'h1234_5678, m, e;
	wire [7:0] io_rdata_r;
	wire [31:0] pin_data, pin_oe, per_level_r;
	integer n_errors = 0, checks = 0, b;
	rcp_pin_select rcp_pin_select_inst (.ref_clk, .reset, .io_addr, .io_wr, .io_rd, .io_wdata,
		.io_rdata_r, .per_out, .per_oe, .pin_level, .pin_data, .pin_oe, .per_level_r);
	initial forever #2.5 ref_clk = ~ref_clk;
	task chk(input string nm, input [31:0] e, g);
		checks = checks + 1;
		if (g !== e) begin
			n_errors = n_errors + 1;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task wr(input [15:0] a, input [7:0] d);
		io_rd = 0;
		io_wr = 1;
		io_addr = a;
		io_wdata = d;
		@(negedge ref_clk);
	endtask
	task rd(input [15:0] a, input [7:0] e);
		io_wr = 0;
		io_rd = 1;
		io_addr = a;
		@(negedge ref_clk);
		chk("read", {24'h0, e}, {24'h0, io_rdata_r});
	endtask
	task wr32(input [15:0] a, input [31:0] d);
		for (int i = 3; i >= 0; i--) wr(16'(a + i), d[8*i +: 8]);
	endtask
	task rd32(input [15:0] a, input [31:0] e);
		for (int i = 0; i < 4; i++) rd(16'(a + i), e[8*i +: 8]);
	endtask
	task pins(input [31:0] eo, eoe);
		io_wr = 0;
		io_rd = 0;
		repeat (2) @(negedge ref_clk);
		chk("pin_data", eo, pin_data);
		chk("pin_oe", eoe, pin_oe);
	endtask
	task t_reset_state;
		rd(16'hefc0, 8'h00);
		rd32(16'hefc4, 0);
		per_oe = 32'hf0f0_0f0f;
		pins(per_out, per_oe);
	endtask
	task t_groups;
		per_oe = 0;
		wr32(16'hefc4, 32'hffff_ffff);
		rd32(16'hefc4, 32'hffff_ffff);
		wr32(16'hefcc, 32'ha5a5_5a5a);
		rd32(16'hefcc, 32'ha5a5_5a5a);
		wr(16'hefc0, 8'h00);
		rd(16'hefc0, 8'h00);
		pins(per_out, 0);
		for (b = 0; b < 8; b = b + 1) begin
			m = b == 7 ? 32'hff00_0000 : b == 6 ? 32'h007f_0000 : b == 5 ? 32'h0000_ff00 :
				b == 4 ? 32'h30 : 32'h1 << b;
			wr(16'hefc0, 8'(1 << b));
			rd(16'hefc0, 8'(1 << b));
			e = (32'ha5a5_5a5a & m) | (per_out & ~m);
			pins(e, m);
		end
		wr32(16'hefc4, 0);
		pins(per_out & ~m | 32'ha5a5_5a5a & m, 0);
	endtask
	task t_input;
		pin_level = 32'hedcb_a987;
		wr(16'hefc0, 8'hff);
		wr32(16'hefc4, 32'hffff_ffff);
		rd32(16'hefc8, 32'hedcb_a987);
		chk("per_level", 32'hedcb_a987, per_level_r);
		rd(16'hefd0, 8'h00);
	endtask
	task t_midreset;
		wr(16'hefc0, 8'hff);
		wr32(16'hefc4, 32'hffff_ffff);
		io_wr = 0;
		reset = 1;
		@(negedge ref_clk);
		reset = 0;
		t_reset_state;
	endtask
	task finish_test;
		if (n_errors == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		repeat (6) @(negedge ref_clk);
		reset = 0;
		t_reset_state;
		t_groups;
		t_input;
		t_midreset;
		finish_test;
	end
	initial begin
		#20000;
		n_errors = n_errors + 1;
		finish_test;
	end
endmodule // testbench
